/* pwmdrv_cfg.svh */
// Constants of the PWM channel driver control block: offsets, fields, resets, timing.
// Assumes inclusion by the top module only, not by pwmdrv_pkg.sv.
`ifndef PWMDRV_CFG_SVH
`define PWMDRV_CFG_SVH
// Register indices (4-bit address)
`define PWMDRV_OFS_OFF      4'h0
`define PWMDRV_OFS_PWE      4'h3
`define PWMDRV_OFS_RHE      4'h4
`define PWMDRV_OFS_PDE      4'h5
`define PWMDRV_OFS_CFG      4'h6
`define PWMDRV_OFS_BC       4'h7
`define PWMDRV_OFS_STOP     4'h8
// Field positions in source_a_and_config
`define PWMDRV_CFG_DUTY_LSB 0
`define PWMDRV_CFG_LOG_BIT  5
`define PWMDRV_CFG_OCC_BIT  6
`define PWMDRV_CFG_CLAMP_SELECT_LSB 7
// Field positions in source_b_c_duty
`define PWMDRV_BC_B_LSB     0
`define PWMDRV_BC_C_LSB     5
// Reset values: outputs off, everything else cleared
`define PWMDRV_RST_OFF      12'hfff
`define PWMDRV_RST_ZERO     12'h000
// Timing: clock 20 MHz
`define PWMDRV_CLK_HZ       20000000
`define PWMDRV_LIN_HZ       25000
`define PWMDRV_LOG_HZ       245
`define PWMDRV_LIN_CYC      (`PWMDRV_CLK_HZ / `PWMDRV_LIN_HZ)
`define PWMDRV_LOG_CYC      (`PWMDRV_CLK_HZ / `PWMDRV_LOG_HZ)
`define PWMDRV_OC_SHORT_US  2000
`define PWMDRV_OC_LONG_US   37000
`define PWMDRV_OC_SHORT_CYC ((`PWMDRV_CLK_HZ / 1000000) * `PWMDRV_OC_SHORT_US)
`define PWMDRV_OC_LONG_CYC  ((`PWMDRV_CLK_HZ / 1000000) * `PWMDRV_OC_LONG_US)
// Relay hold target, millivolts
`define PWMDRV_HOLD_MV      11000
`endif

/* pwmdrv_pkg.sv */
// Types of the PWM channel driver control block.
// Widths are literal here; pwmdrv_cfg.svh is not included.
package pwmdrv_pkg;
  typedef logic [11:0] pwmdrv_chan_t;
  typedef logic [4:0]  pwmdrv_code_t;

  // Register write request from the serial front end
  typedef struct packed {
    logic        wr;
    logic [3:0]  addr;
    logic [11:0] data;
  } pwmdrv_wr_s;

  // Whole state of the block
  typedef struct packed {
    pwmdrv_chan_t off;
    pwmdrv_chan_t pwe;
    pwmdrv_chan_t rhe;
    pwmdrv_chan_t pde;
    logic [11:0]  cfg;
    logic [11:0]  bc;
    pwmdrv_chan_t stop;
    logic [19:0]  cnt;
    logic [9:0]   rly_cnt;
    logic [9:0]   rly_hi;
    logic [2:0]   src;
    logic         rly;
    pwmdrv_chan_t drv;
    logic [11:0]  rdata;
  } pwmdrv_state_s;
endpackage

/* pwmdrv_top.sv */
// PWM channel driver control: three shared PWM sources, per-channel mode logic.
// Assumes a serial front end delivering register writes/reads synchronous to mclk,
// and an ADC word for the battery-sense pin in millivolts.
`timescale 1ns/1ps
`include "pwmdrv_cfg.svh"

// Functional notes
// - Channels 0,3,6,9 follow A; 1,4,7,10 follow B; 2,5,8,11 follow C.
// - Eight-channel variant: channels 8 to 11 absent, held off.
// - Three sources share one frequency, each own duty; each channel may use PWM.
// - Linear code 0 gives 3 percent high, code 31 permanently on.
// - Log select bit clear selects linear duty scaling.
// - Linear mode period corresponds to 25 kHz.
// - Log select set: 245 Hz, 32 logarithmic duties from 0.1 to 100 percent.
// - LED channel may be constant off, constant on, or PWM.
// - Pulse enable bit makes channel follow its source instead of constant on.
// - Off bit 1 forces channel off regardless of other bits; 0 activates.
// - Relay adapt bit set places channel in supply-adapted PWM.
// - Source A duty in register 6, sources B and C in register 7.
// - Adapted duty from battery sense: 100 percent low, about 11 V effective high.
// - Relay adapt set ignores pulse enable, duty codes and log select.
// - All adapted channels share one 25 kHz signal and one duty.
// - Off 0 with adapt 0 is pull-in on; adapt 1 is hold with PWM.
// - Over-current delay select: 1 gives 2 ms, 0 gives 37 ms.
module pwmdrv_top
  import pwmdrv_pkg::*;
#(
  parameter bit TWELVE_CH = 1'b1
) (
  // Clock and reset
  input  wire logic         mclk,
  input  wire logic         reset_n,
  // Register access
  input  wire pwmdrv_wr_s   reg_req,
  output logic [11:0]       reg_rdata,
  // Battery sense measurement, millivolts
  input  wire logic [15:0]  vbat_mv,
  // Driver controls
  output pwmdrv_chan_t      chan_on,
  output pwmdrv_chan_t      chan_pulldown_enable,
  output pwmdrv_chan_t      motor_stall_halt,
  output logic [1:0]        clamp_select,
  output logic              overcurrent_delay_select,
  output logic [21:0]       overcurrent_delay_cyc
);

  localparam int LIN_CYC = `PWMDRV_LIN_CYC;
  localparam int LOG_CYC = `PWMDRV_LOG_CYC;
  localparam logic [21:0] OC_SHORT = 22'(`PWMDRV_OC_SHORT_CYC);
  localparam logic [21:0] OC_LONG  = 22'(`PWMDRV_OC_LONG_CYC);
  localparam pwmdrv_chan_t CH_MASK = TWELVE_CH ? 12'hfff : 12'h0ff;

  pwmdrv_state_s s_q;
  pwmdrv_state_s s_d;

  // Linear threshold: 3 percent at code 0, full at code 31, straight steps between
  function automatic logic [19:0] lin_thr(input pwmdrv_code_t c);
    logic [19:0] lo;
    lo = 20'((LIN_CYC * 3) / 100);
    if (c == 5'h1f)
      lin_thr = 20'(LIN_CYC);
    else
      lin_thr = lo + 20'(((LIN_CYC - ((LIN_CYC * 3) / 100)) * int'(c)) / 31);
  endfunction

  // Logarithmic table in tenths of a percent, roughly x1.25 per step, 1 to 1000
  function automatic logic [19:0] log_thr(input pwmdrv_code_t c);
    logic [9:0] pm;
    case (c)
      5'h00: pm = 10'd1;   5'h01: pm = 10'd2;   5'h02: pm = 10'd2;   5'h03: pm = 10'd3;
      5'h04: pm = 10'd3;   5'h05: pm = 10'd4;   5'h06: pm = 10'd5;   5'h07: pm = 10'd6;
      5'h08: pm = 10'd8;   5'h09: pm = 10'd10;  5'h0a: pm = 10'd12;  5'h0b: pm = 10'd15;
      5'h0c: pm = 10'd19;  5'h0d: pm = 10'd24;  5'h0e: pm = 10'd30;  5'h0f: pm = 10'd37;
      5'h10: pm = 10'd46;  5'h11: pm = 10'd58;  5'h12: pm = 10'd72;  5'h13: pm = 10'd90;
      5'h14: pm = 10'd112; 5'h15: pm = 10'd140; 5'h16: pm = 10'd175; 5'h17: pm = 10'd218;
      5'h18: pm = 10'd272; 5'h19: pm = 10'd340; 5'h1a: pm = 10'd425; 5'h1b: pm = 10'd530;
      5'h1c: pm = 10'd640; 5'h1d: pm = 10'd760; 5'h1e: pm = 10'd880; 5'h1f: pm = 10'd1000;
      default: pm = 10'd1000;
    endcase
    log_thr = 20'((LOG_CYC * int'(pm)) / 1000);
  endfunction

  // Read mux shared by register reads
  function automatic logic [11:0] rd_mux(input pwmdrv_state_s s, input logic [3:0] a);
    case (a)
      `PWMDRV_OFS_OFF:  rd_mux = s.off;
      `PWMDRV_OFS_PWE:  rd_mux = s.pwe;
      `PWMDRV_OFS_RHE:  rd_mux = s.rhe;
      `PWMDRV_OFS_PDE:  rd_mux = s.pde;
      `PWMDRV_OFS_CFG:  rd_mux = s.cfg;
      `PWMDRV_OFS_BC:   rd_mux = s.bc;
      `PWMDRV_OFS_STOP: rd_mux = s.stop;
      default:          rd_mux = 12'h000;
    endcase
  endfunction

  // Next-state logic
  always_comb begin
    logic [19:0]  per;
    logic [19:0]  thr [3];
    pwmdrv_code_t code [3];
    logic [31:0]  hi_calc;
    logic         logm;
    per = 20'h0;
    hi_calc = 32'h0;
    for (int i = 0; i < 3; i++) begin
      thr[i] = 20'h0;
      code[i] = 5'h00;
    end
    s_d = s_q;
    logm = s_q.cfg[`PWMDRV_CFG_LOG_BIT];

    // Register writes; unused channels stay masked
    if (reg_req.wr) begin
      case (reg_req.addr)
        `PWMDRV_OFS_OFF:  s_d.off  = reg_req.data | ~CH_MASK;
        `PWMDRV_OFS_PWE:  s_d.pwe  = reg_req.data & CH_MASK;
        `PWMDRV_OFS_RHE:  s_d.rhe  = reg_req.data & CH_MASK;
        `PWMDRV_OFS_PDE:  s_d.pde  = reg_req.data & CH_MASK;
        `PWMDRV_OFS_CFG:  s_d.cfg  = reg_req.data;
        `PWMDRV_OFS_BC:   s_d.bc   = reg_req.data & 12'h3ff;
        `PWMDRV_OFS_STOP: s_d.stop = reg_req.data & 12'h007;
        default:          s_d.off  = s_q.off;
      endcase
    end
    s_d.rdata = rd_mux(s_q, reg_req.addr);

    // Shared source counter; period follows the scaling mode
    per = logm ? 20'(LOG_CYC) : 20'(LIN_CYC);
    s_d.cnt = (s_q.cnt >= per - 20'd1) ? 20'h0 : s_q.cnt + 20'd1;
    code[0] = s_q.cfg[`PWMDRV_CFG_DUTY_LSB +: 5];
    code[1] = s_q.bc[`PWMDRV_BC_B_LSB +: 5];
    code[2] = s_q.bc[`PWMDRV_BC_C_LSB +: 5];
    for (int i = 0; i < 3; i++) begin
      thr[i] = logm ? log_thr(code[i]) : lin_thr(code[i]);
      s_d.src[i] = (s_q.cnt < thr[i]);
    end

    // Relay source: own 25 kHz counter, duty = 11 V / VBAT capped at full
    s_d.rly_cnt = (32'(s_q.rly_cnt) >= LIN_CYC - 1) ? 10'h0 : s_q.rly_cnt + 10'd1;
    if (vbat_mv <= 16'(`PWMDRV_HOLD_MV))
      hi_calc = 32'(LIN_CYC);
    else
      hi_calc = (32'(LIN_CYC) * 32'(`PWMDRV_HOLD_MV)) / 32'(vbat_mv);
    if (s_q.rly_cnt == 10'h0)
      s_d.rly_hi = hi_calc[9:0]; // Latched per period to avoid mid-pulse glitches
    s_d.rly = (s_q.rly_cnt < s_q.rly_hi);

    // Per-channel mode selection
    for (int ch = 0; ch < 12; ch++) begin
      if (s_q.off[ch] || !CH_MASK[ch])
        s_d.drv[ch] = 1'b0;
      else if (s_q.rhe[ch])
        s_d.drv[ch] = s_q.rly;
      else if (s_q.pwe[ch])
        s_d.drv[ch] = s_q.src[ch % 3];
      else
        s_d.drv[ch] = 1'b1;
    end
  end

  // State register
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      s_q.off     <= `PWMDRV_RST_OFF;
      s_q.pwe     <= `PWMDRV_RST_ZERO;
      s_q.rhe     <= `PWMDRV_RST_ZERO;
      s_q.pde     <= `PWMDRV_RST_ZERO;
      s_q.cfg     <= `PWMDRV_RST_ZERO;
      s_q.bc      <= `PWMDRV_RST_ZERO;
      s_q.stop    <= `PWMDRV_RST_ZERO;
      s_q.cnt     <= 20'h0;
      s_q.rly_cnt <= 10'h0;
      s_q.rly_hi  <= 10'h0;
      s_q.src     <= 3'h0;
      s_q.rly     <= 1'b0;
      s_q.drv     <= 12'h000;
      s_q.rdata   <= 12'h000;
    end else begin
      s_q <= s_d;
    end
  end

  // Outputs straight from the state flops
  assign chan_on                  = s_q.drv;
  assign reg_rdata                = s_q.rdata;
  assign chan_pulldown_enable     = s_q.pde;
  assign motor_stall_halt         = s_q.stop;
  assign clamp_select             = s_q.cfg[`PWMDRV_CFG_CLAMP_SELECT_LSB +: 2];
  assign overcurrent_delay_select = s_q.cfg[`PWMDRV_CFG_OCC_BIT];
  // Delay handed to the protection timer
  assign overcurrent_delay_cyc    = s_q.cfg[`PWMDRV_CFG_OCC_BIT] ? OC_SHORT : OC_LONG;

endmodule

/* pwmdrv_mcu.sv */
// Controller model: issues register writes and reads on the request port.
// Assumes the block samples requests on the rising mclk edge.
`timescale 1ns/1ps
module pwmdrv_mcu
  import pwmdrv_pkg::*;
(
  // Clock
  input  wire logic        mclk,
  // Request and answer
  output pwmdrv_wr_s       req,
  input  wire logic [11:0] rdata
);
  initial req = '0;
  // One-cycle strobe; data flips afterwards so stale values never look valid
  task automatic write(input logic [3:0] a, input logic [11:0] d);
    @(posedge mclk) req <= '{wr: 1'b1, addr: a, data: d};
    @(posedge mclk) req <= '{wr: 1'b0, addr: a, data: ~d};
  endtask
  // Answer is registered, so it is taken two edges later
  task automatic read(input logic [3:0] a, output logic [11:0] d);
    @(posedge mclk) req <= '{wr: 1'b0, addr: a, data: ~req.data};
    repeat (2) @(posedge mclk);
    d = rdata;
  endtask
endmodule

/* pwmdrv_props.sv */
// Port checker of the PWM channel driver control block.
// Assumes it is bound to pwmdrv_top; shadows the mode registers itself.
`timescale 1ns/1ps
module pwmdrv_props
  import pwmdrv_pkg::*;
#(
  parameter bit TWELVE_CH = 1'b1
) (
  // Clock and reset
  input wire logic         mclk,
  input wire logic         reset_n,
  // Register access and battery sense
  input wire pwmdrv_wr_s   reg_req,
  input wire logic [11:0]  reg_rdata,
  input wire logic [15:0]  vbat_mv,
  // Driver controls
  input wire pwmdrv_chan_t chan_on,
  input wire pwmdrv_chan_t chan_pulldown_enable,
  input wire pwmdrv_chan_t motor_stall_halt,
  input wire logic [1:0]   clamp_select,
  input wire logic         overcurrent_delay_select,
  input wire logic [21:0]  overcurrent_delay_cyc
);
  default clocking @(posedge mclk); endclocking
  default disable iff (!reset_n);
  logic [11:0] off_q, pwe_q, rhe_q, relay_m;
  logic [1:0]  quiet_q;
  // Shadows; quiet_q saturates so checks wait out the two-stage pipeline
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      off_q <= 12'hfff;
      pwe_q <= 12'h000;
      rhe_q <= 12'h000;
      quiet_q <= 2'h0;
    end else begin
      if (reg_req.wr && reg_req.addr == 4'h0) off_q <= reg_req.data;
      if (reg_req.wr && reg_req.addr == 4'h3) pwe_q <= reg_req.data;
      if (reg_req.wr && reg_req.addr == 4'h4) rhe_q <= reg_req.data;
      quiet_q <= reg_req.wr ? 2'h0 : (quiet_q == 2'h3 ? 2'h3 : quiet_q + 2'h1);
    end
  end
  assign relay_m = rhe_q & ~off_q;
  sequence s_all_off;
    reg_req.wr && reg_req.addr == 4'h0 && reg_req.data == 12'hfff;
  endsequence
  a_off_forces_low: assert property (quiet_q == 2'h3 |-> (chan_on & off_q) == 12'h000)
    else $error("off channel driven");
  a_off_response: assert property (s_all_off |-> ##3 chan_on == 12'h000)
    else $error("all-off write not obeyed");
  a_pullin_full: assert property (quiet_q == 2'h3 |-> &(chan_on | off_q | rhe_q | pwe_q))
    else $error("pull-in channel not on");
  a_relay_common: assert property (quiet_q == 2'h3 |->
    (chan_on & relay_m) == 12'h000 || (chan_on & relay_m) == relay_m)
    else $error("relay channels differ");
  a_delay_short: assert property (overcurrent_delay_select |-> overcurrent_delay_cyc == 22'd40000)
    else $error("short delay wrong");
  a_delay_long: assert property (!overcurrent_delay_select |-> overcurrent_delay_cyc == 22'd740000)
    else $error("long delay wrong");
  a_cfg_follows: assert property (reg_req.wr && reg_req.addr == 4'h6 |=>
    {clamp_select, overcurrent_delay_select} == $past(reg_req.data[8:6]))
    else $error("config fields not taken");
  a_unmapped_zero: assert property (!(reg_req.addr inside {4'h0, [4'h3:4'h8]}) |=> reg_rdata == 12'h000)
    else $error("unmapped read not zero");
  a_pulldown_follows: assert property (reg_req.wr && reg_req.addr == 4'h5 |=>
    chan_pulldown_enable == $past(reg_req.data))
    else $error("pull-down enables not taken");
  a_stall_halt_follows: assert property (reg_req.wr && reg_req.addr == 4'h8 |=>
    motor_stall_halt == ($past(reg_req.data) & 12'h007))
    else $error("stall halt bits not taken");
endmodule
bind pwmdrv_top pwmdrv_props #(.TWELVE_CH(TWELVE_CH)) pwmdrv_props_inst (.mclk(mclk),
  .reset_n(reset_n), .reg_req(reg_req), .reg_rdata(reg_rdata), .vbat_mv(vbat_mv),
  .chan_on(chan_on), .chan_pulldown_enable(chan_pulldown_enable),
  .motor_stall_halt(motor_stall_halt), .clamp_select(clamp_select),
  .overcurrent_delay_select(overcurrent_delay_select),
  .overcurrent_delay_cyc(overcurrent_delay_cyc));

/* test_pwm_channel_driver_control.sv */
// Self-checking bench: register readback, then duty counts of all channels per mode.
// Assumes the 12-channel build and the controller model pwmdrv_mcu.
`timescale 1ns/1ps
module test_pwm_channel_driver_control
  import pwmdrv_pkg::*;
;
  logic         mclk = 1'b0;
  logic         reset_n = 1'b0;
  logic [15:0]  vbat_mv = 16'd24000;
  pwmdrv_wr_s   reg_req;
  logic [11:0]  reg_rdata, rd, d, off, pwe, rhe, cfg, bc;
  pwmdrv_chan_t chan_on;
  logic [31:0]  seed = 32'h8;
  int           bad_count = 0;
  int           samples_checked = 0;
  always #25 mclk = ~mclk;
  pwmdrv_mcu pwmdrv_mcu_inst (.mclk(mclk), .req(reg_req), .rdata(reg_rdata));
  pwmdrv_top pwmdrv_top_inst (.mclk(mclk), .reset_n(reset_n), .reg_req(reg_req),
    .reg_rdata(reg_rdata), .vbat_mv(vbat_mv), .chan_on(chan_on), .chan_pulldown_enable(),
    .motor_stall_halt(), .clamp_select(), .overcurrent_delay_select(),
    .overcurrent_delay_cyc());
  function automatic logic [31:0] xs();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  // High cycles per 800-cycle period expected on one channel
  function automatic int exp_high(int ch);
    logic [4:0] c = ch % 3 == 0 ? cfg[4:0] : ch % 3 == 1 ? bc[4:0] : bc[9:5];
    if (off[ch]) return 0;
    if (rhe[ch]) return vbat_mv <= 16'd11000 ? 800 : 800 * 11000 / vbat_mv;
    return !pwe[ch] ? 800 : c == 5'h1f ? 800 : 24 + 776 * c / 31;
  endfunction
  task automatic check(int got, int want);
    samples_checked++;
    if (got != want) begin
      bad_count++;
      $display("unexpected %0t high count %0d want %0d", $time, got, want);
    end
  endtask
  task automatic check_reg(logic [11:0] got, logic [11:0] want);
    samples_checked++;
    if (got !== want) begin
      bad_count++;
      $display("unexpected %0t register %h want %h", $time, got, want);
    end
  endtask
  // Settle two periods, then count one whole period on every channel
  task automatic sweep();
    int hi[12];
    repeat (1600) @(posedge mclk);
    repeat (800) begin
      @(posedge mclk);
      foreach (hi[i]) hi[i] += int'(chan_on[i] === 1'b1);
    end
    foreach (hi[i]) check(hi[i], exp_high(i));
  endtask
  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", samples_checked, bad_count);
    if (bad_count == 0 && samples_checked > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  initial begin
    repeat (60000) @(posedge mclk);
    bad_count++;
    $display("unexpected %0t watchdog expired", $time);
    tally_and_finish();
  end
  initial begin
    repeat (6) @(posedge mclk);
    reset_n <= 1'b1;
    // Reset value, then random write and readback, unmapped places included
    for (int a = 0; a < 16; a++) begin
      pwmdrv_mcu_inst.read(a[3:0], rd);
      check_reg(rd, a == 0 ? 12'hfff : 12'h000);
      d = 12'(xs());
      pwmdrv_mcu_inst.write(a[3:0], d);
      pwmdrv_mcu_inst.read(a[3:0], rd);
      check_reg(rd, a == 7 ? d & 12'h3ff : a == 8 ? d & 12'h007 :
        a inside {0, [3:6]} ? d : 12'h000);
    end
    pwmdrv_mcu_inst.write(4'h5, 12'h000);
    pwmdrv_mcu_inst.write(4'h8, 12'h000);
    // Corners, pull-in then hold, random modes, log mode, all off
    for (int r = 0; r < 6; r++) begin
      @(posedge mclk) vbat_mv <= r == 0 ? 16'd9000 : 16'd11001 + 16'(xs() % 19000);
      off = r == 5 ? 12'hfff : r < 2 ? 12'h000 : 12'(xs() & xs());
      pwe = 12'(xs());
      rhe = r < 2 ? 12'h000 : 12'(xs());
      cfg = (r == 4 ? 12'h03f : r == 0 ? 12'h000 : 12'(xs()) & 12'h01f) | 12'(xs()) & 12'h1c0;
      bc = r == 4 ? 12'h3ff : r == 0 ? 12'h01f | 12'(xs()) & 12'h3e0 : 12'(xs()) & 12'h3ff;
      pwmdrv_mcu_inst.write(4'h0, off);
      pwmdrv_mcu_inst.write(4'h3, pwe);
      pwmdrv_mcu_inst.write(4'h4, rhe);
      pwmdrv_mcu_inst.write(4'h6, cfg);
      pwmdrv_mcu_inst.write(4'h7, bc);
      sweep();
    end
    tally_and_finish();
  end
endmodule
